// file: inc/adc_mode_defs.vh
// Constants of the converter operating-mode controller
// Summary of operation
// - Mode 0000, reset default, converts repeatedly into the data register.
// - Ready indicator goes low whenever a conversion finishes.
// - Continuous read shifts each result out on serial clocks without a command.
// - No valid result until full filter settling after reset or reconfiguration; only a mode change restarts settling, other writes do not.
// - After the first result, further results come at the output data rate.
// - Mode 0001 performs exactly one conversion taking the full settling time.
// - Single conversion stores result, drives ready low, then enters standby.
// - After single conversion, result and ready low hold until read or restart.
// - Mode 0010 powers down all but the on-chip regulators, registers kept.
// - In standby, reference, oscillator, power switch and bias are individually enabled.
// - In standby, enabled diagnostics keep running and may be toggled.
// - Clocked diagnostics enabled during standby stay inoperative.
// - Mode 0011 switches off every circuit including clocks and regulators.
// - Power-down loses every programmed register value except the mode field.
// - Mode field sits in control register bits 5 to 2.
// - Mode 0100 holds filter and modulator in reset, clocks kept running.
`ifndef ADC_MODE_DEFS_VH
`define ADC_MODE_DEFS_VH

`define OFS_CTRL        8'h00
`define OFS_DIAG        8'h04
`define OFS_STATUS      8'h08
`define OFS_DATA        8'h0c
`define OFS_COMM        8'h10

`define CTRL_MODE_LSB   2
`define CTRL_MODE_MSB   5
`define CTRL_REF_EN     8
`define CTRL_CONT_READ  11
`define CTRL_OSC_EN     12
`define CTRL_PSW_EN     13
`define CTRL_BIAS_EN    14
`define COMM_READ_REQ   0

`define MODE_CONT       4'h0
`define MODE_SINGLE     4'h1
`define MODE_STANDBY    4'h2
`define MODE_PDOWN      4'h3
`define MODE_IDLE       4'h4

`define RST_REF_EN      1'b0
`define RST_CONT_READ   1'b0
`define RST_OSC_EN      1'b1
`define RST_PSW_EN      1'b0
`define RST_BIAS_EN     1'b0
`define RST_DIAG        8'h00
`define DIAG_CLK_MASK   8'h1f

`define MCLK_DIV        8
`define SETTLE_TICKS    16'd64
`define ODR_TICKS       16'd16
`define RESULT_BITS     24

`endif

// file: hw/result_fifo.v
// Result buffer with registered read stage
`timescale 1ns/1ps
module result_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock,
   input  wire             reset,
   input  wire             flush,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output reg              out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wp_q;
   reg  [AW-1:0]    rp_q;
   reg  [AW:0]      cnt_q;
   wire             push;
   wire             pop;
   wire             load;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   // Refill the output stage as soon as it empties
   assign load     = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | pop);

   always @(posedge clock) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         wp_q      <= {AW{1'b0}};
         rp_q      <= {AW{1'b0}};
         cnt_q     <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {WIDTH{1'b0}};
      end else if (flush) begin
         wp_q      <= {AW{1'b0}};
         rp_q      <= {AW{1'b0}};
         cnt_q     <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (load) begin
            out_data  <= mem[rp_q];
            rp_q      <= rp_q + 1'b1;
            out_valid <= 1'b1;
         end else if (pop) begin
            out_valid <= 1'b0;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      end
   end
endmodule

// file: hw/adc_mode_ctrl.v
// Operating-mode controller: conversion sequencing, power gating, result readout
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "adc_mode_defs.vh"
module adc_mode_ctrl #(
   parameter MCLK_DIV     = `MCLK_DIV,
   parameter SETTLE_TICKS = `SETTLE_TICKS,
   parameter ODR_TICKS    = `ODR_TICKS,
   parameter DEPTH        = 16
) (
   input  wire        clock,
   input  wire        reset,
   input  wire [7:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire [23:0] conv_data,
   input  wire        sclk,
   input  wire        cs_n,
   output reg         dout,
   output reg         ready_n,
   output reg         regulators_on,
   output reg         clocks_on,
   output reg         osc_on,
   output reg         ref_on,
   output reg         psw_on,
   output reg         bias_on,
   output reg         modulator_run,
   output reg         filter_rst,
   output reg  [7:0]  diag_run
);
   localparam RB = `RESULT_BITS;

   // Shifter states, one-hot
   localparam SH_IDLE  = 2'b01;
   localparam SH_SHIFT = 2'b10;

   reg  [3:0]    mode_q;
   reg           ref_en_q;
   reg           cont_read_q;
   reg           osc_en_q;
   reg           psw_en_q;
   reg           bias_en_q;
   reg  [7:0]    diag_en_q;
   reg  [7:0]    diag_armed_q;
   reg           read_req_q;
   reg  [7:0]    div_q;
   reg           tick_q;
   reg  [15:0]   cnt_q;
   reg           settled_q;
   reg           single_done_q;
   reg  [2:0]    sclk_s_q;
   reg  [1:0]    cs_s_q;
   reg  [1:0]    sh_state_q;
   reg  [RB-1:0] sh_q;
   reg  [4:0]    bit_cnt_q;
   wire          ctrl_wr;
   wire [3:0]    new_mode;
   wire          mode_chg;
   wire          running;
   wire          conv_end;
   wire          res_valid;
   wire          res_ready;
   wire          head_valid;
   wire [RB-1:0] head_data;
   wire          reg_pop;
   wire          ser_load;
   wire          head_pop;
   wire          sclk_fall;
   wire          pdown;

   function is_active;
      input [3:0] m;
      begin
         is_active = (m == `MODE_CONT) | (m == `MODE_IDLE);
      end
   endfunction

   assign ctrl_wr   = wr & (addr == `OFS_CTRL);
   assign new_mode  = wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
   assign mode_chg  = ctrl_wr & (new_mode != mode_q);
   assign pdown     = (mode_q == `MODE_PDOWN);
   assign running   = (mode_q == `MODE_CONT) |
                      ((mode_q == `MODE_SINGLE) & ~single_done_q);
   assign conv_end  = running & tick_q & (cnt_q == 16'd1) & ~mode_chg;
   // A full buffer stalls the conversion rather than dropping a result
   assign res_valid = conv_end;
   assign reg_pop   = rd & (addr == `OFS_DATA) & head_valid;
   assign ser_load  = (sh_state_q == SH_IDLE) & head_valid & ~reg_pop &
                      (cont_read_q | read_req_q);
   assign head_pop  = reg_pop | ser_load;
   assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1] & ~cs_s_q[1];

   result_fifo #(
      .WIDTH (RB),
      .DEPTH (DEPTH),
      .AW    (4)
   ) u_fifo (
      .clock     (clock),
      .reset     (reset),
      .flush     (mode_chg | pdown),
      .in_valid  (res_valid),
      .in_ready  (res_ready),
      .in_data   (conv_data),
      .out_valid (head_valid),
      .out_ready (head_pop),
      .out_data  (head_data)
   );

   // Modulator clock enable; stops entirely when clocks are off
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         div_q  <= 8'h00;
         tick_q <= 1'b0;
      end else if (pdown || mode_q == `MODE_STANDBY) begin
         div_q  <= 8'h00;
         tick_q <= 1'b0;
      end else if (div_q == MCLK_DIV[7:0] - 8'h01) begin
         div_q  <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 8'h01;
         tick_q <= 1'b0;
      end
   end

   // Configuration registers
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_q      <= `MODE_CONT;
         ref_en_q    <= `RST_REF_EN;
         cont_read_q <= `RST_CONT_READ;
         osc_en_q    <= `RST_OSC_EN;
         psw_en_q    <= `RST_PSW_EN;
         bias_en_q   <= `RST_BIAS_EN;
         diag_en_q   <= `RST_DIAG;
         read_req_q  <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            mode_q      <= new_mode;
            ref_en_q    <= wdata[`CTRL_REF_EN];
            cont_read_q <= wdata[`CTRL_CONT_READ];
            osc_en_q    <= wdata[`CTRL_OSC_EN];
            psw_en_q    <= wdata[`CTRL_PSW_EN];
            bias_en_q   <= wdata[`CTRL_BIAS_EN];
         end else if (pdown) begin
            // Nothing survives power-down but the mode field itself
            ref_en_q    <= `RST_REF_EN;
            cont_read_q <= `RST_CONT_READ;
            osc_en_q    <= `RST_OSC_EN;
            psw_en_q    <= `RST_PSW_EN;
            bias_en_q   <= `RST_BIAS_EN;
         end else if (conv_end && res_ready && mode_q == `MODE_SINGLE) begin
            mode_q <= `MODE_STANDBY;
         end
         if (wr && addr == `OFS_DIAG) begin
            diag_en_q <= wdata[7:0];
         end else if (pdown) begin
            diag_en_q <= `RST_DIAG;
         end
         // A fresh request beats the load that consumes the previous one
         if (wr && addr == `OFS_COMM) begin
            read_req_q <= wdata[`COMM_READ_REQ];
         end else if (ser_load || pdown) begin
            read_req_q <= 1'b0;
         end
      end
   end

   // Clocked diagnostics only work if switched on in continuous or idle mode
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         diag_armed_q <= 8'h00;
      end else if (wr && addr == `OFS_DIAG) begin
         if (is_active(mode_q)) begin
            diag_armed_q <= wdata[7:0];
         end else begin
            diag_armed_q <= diag_armed_q & wdata[7:0];
         end
      end else if (pdown) begin
         diag_armed_q <= 8'h00;
      end
   end

   // Conversion sequencer
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_q         <= SETTLE_TICKS[15:0];
         settled_q     <= 1'b0;
         single_done_q <= 1'b0;
      end else if (mode_chg) begin
         cnt_q         <= SETTLE_TICKS[15:0];
         settled_q     <= 1'b0;
         single_done_q <= 1'b0;
      end else if (!running) begin
         cnt_q     <= SETTLE_TICKS[15:0];
         settled_q <= 1'b0;
      end else if (conv_end) begin
         if (res_ready) begin
            cnt_q     <= ODR_TICKS[15:0];
            settled_q <= 1'b1;
            if (mode_q == `MODE_SINGLE) begin
               single_done_q <= 1'b1;
            end
         end
      end else if (tick_q) begin
         cnt_q <= cnt_q - 16'd1;
      end
   end

   // Ready indicator: a new result beats a simultaneous read
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         ready_n <= 1'b1;
      end else if (conv_end && res_ready) begin
         ready_n <= 1'b0;
      end else if (mode_chg || pdown) begin
         ready_n <= 1'b1;
      end else if (head_pop) begin
         ready_n <= 1'b1;
      end
   end

   // Serial pins come from another domain
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sclk_s_q <= 3'b000;
         cs_s_q   <= 2'b11;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], sclk};
         cs_s_q   <= {cs_s_q[0], cs_n};
      end
   end

   // Result shifter, MSB first, data changes on the falling serial edge
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sh_state_q <= SH_IDLE;
         sh_q       <= {RB{1'b0}};
         bit_cnt_q  <= 5'h00;
         dout       <= 1'b0;
      end else begin
         case (sh_state_q)
            SH_IDLE: begin
               if (ser_load) begin
                  sh_q       <= head_data;
                  dout       <= head_data[RB-1];
                  bit_cnt_q  <= 5'h00;
                  sh_state_q <= SH_SHIFT;
               end
            end
            SH_SHIFT: begin
               if (pdown) begin
                  sh_state_q <= SH_IDLE;
                  dout       <= 1'b0;
               end else if (sclk_fall) begin
                  if (bit_cnt_q == 5'h17) begin
                     sh_state_q <= SH_IDLE;
                     dout       <= 1'b0;
                  end else begin
                     sh_q      <= {sh_q[RB-2:0], 1'b0};
                     dout      <= sh_q[RB-2];
                     bit_cnt_q <= bit_cnt_q + 5'h01;
                  end
               end
            end
            default: begin
               sh_state_q <= SH_IDLE;
            end
         endcase
      end
   end

   // Power and clock gating per mode
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         regulators_on <= 1'b1;
         clocks_on     <= 1'b1;
         osc_on        <= 1'b1;
         ref_on        <= 1'b0;
         psw_on        <= 1'b0;
         bias_on       <= 1'b0;
         modulator_run <= 1'b0;
         filter_rst    <= 1'b1;
         diag_run      <= 8'h00;
      end else begin
         regulators_on <= ~pdown;
         clocks_on     <= ~pdown & (mode_q != `MODE_STANDBY);
         osc_on        <= ~pdown & osc_en_q;
         ref_on        <= ~pdown & ref_en_q;
         psw_on        <= ~pdown & psw_en_q;
         bias_on       <= ~pdown & bias_en_q;
         modulator_run <= running & ~mode_chg;
         filter_rst    <= ~running | (mode_q == `MODE_IDLE);
         if (pdown) begin
            diag_run <= 8'h00;
         end else begin
            diag_run <= diag_en_q & (~`DIAG_CLK_MASK | diag_armed_q);
         end
      end
   end

   // Register read port, data one cycle after the strobe
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            `OFS_CTRL: begin
               rdata <= {17'h00000, bias_en_q, psw_en_q, osc_en_q, cont_read_q,
                         2'b00, ref_en_q, 2'b00, mode_q, 2'b00};
            end
            `OFS_DIAG: begin
               rdata <= {24'h000000, diag_en_q};
            end
            `OFS_STATUS: begin
               rdata <= {24'h000000, head_valid, single_done_q, mode_q,
                         settled_q, ready_n};
            end
            `OFS_DATA: begin
               rdata <= head_valid ? {8'h00, head_data} : 32'h0000_0000;
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end
   end
endmodule

// file: test/adc_mode_props.sv
// Port-level checker for the operating-mode controller
`timescale 1ns/1ps
module adc_mode_props #(
   parameter MCLK_DIV     = 8,
   parameter SETTLE_TICKS = 64
) (
   input wire        clock,
   input wire        reset,
   input wire [7:0]  addr,
   input wire [31:0] wdata,
   input wire        wr,
   input wire        ready_n,
   input wire        regulators_on,
   input wire        clocks_on,
   input wire        osc_on,
   input wire        ref_on,
   input wire        psw_on,
   input wire        bias_on,
   input wire        modulator_run,
   input wire        filter_rst,
   input wire [7:0]  diag_run
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   reg  [3:0]  mode_q;
   reg  [15:0] since_q;
   reg  [15:0] high_q;
   wire        ctrl_wr  = wr && addr == 8'h00;
   wire        mode_chg = ctrl_wr && wdata[5:2] != mode_q;
   // Mode follows writes only; the automatic return to standby is not tracked
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_q  <= 4'h0;
         since_q <= 16'h0000;
         high_q  <= 16'h0000;
      end else begin
         if (ctrl_wr)
            mode_q <= wdata[5:2];
         since_q <= mode_chg ? 16'h0000 : (&since_q ? since_q : since_q + 16'h0001);
         high_q  <= (ready_n && mode_q == 4'h0 && !ctrl_wr) ? high_q + 16'h0001 : 16'h0000;
      end
   end
   property p_pdown;
      ctrl_wr && wdata[5:2] == 4'h3 |->
         ##[1:3] !(regulators_on | clocks_on | osc_on | ref_on | psw_on | bias_on);
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down left a supply on");
   property p_standby;
      ctrl_wr && wdata[5:2] == 4'h2 |-> ##[1:3] regulators_on && !modulator_run;
   endproperty
   a_standby: assert property (p_standby) else $error("standby power state wrong");
   property p_ref;
      ctrl_wr && wdata[5:2] == 4'h2 && wdata[8] |-> ##[1:3] ref_on;
   endproperty
   a_ref: assert property (p_ref) else $error("reference not enabled in standby");
   property p_idle;
      ctrl_wr && wdata[5:2] == 4'h4 |-> ##[1:3] filter_rst && clocks_on && !modulator_run;
   endproperty
   a_idle: assert property (p_idle) else $error("idle state wrong");
   property p_diag_clk;
      wr && addr == 8'h04 && mode_q == 4'h2 |-> ##[1:3] diag_run[4:0] == 5'h00;
   endproperty
   a_diag_clk: assert property (p_diag_clk) else $error("clocked diagnostic ran");
   property p_settle;
      $fell(ready_n) |-> since_q >= (SETTLE_TICKS - 1) * MCLK_DIV;
   endproperty
   a_settle: assert property (p_settle) else $error("result before settling");
   property p_hold;
      $fell(ready_n) && mode_q == 4'h1 |=> !ready_n [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("single result not held");
   // Bound allows for a stalled buffer releasing one tick late
   property p_cont;
      high_q < SETTLE_TICKS * MCLK_DIV + 16;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous mode stopped");
   c_single: cover property ($fell(ready_n) && mode_q == 4'h1);
   c_pdown: cover property (ctrl_wr && wdata[5:2] == 4'h3);
   c_cont: cover property ($fell(ready_n) && mode_q == 4'h0);
endmodule

bind adc_mode_ctrl adc_mode_props #(.MCLK_DIV(MCLK_DIV), .SETTLE_TICKS(SETTLE_TICKS)) u_props (
   .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .ready_n(ready_n),
   .regulators_on(regulators_on), .clocks_on(clocks_on), .osc_on(osc_on), .ref_on(ref_on),
   .psw_on(psw_on), .bias_on(bias_on), .modulator_run(modulator_run),
   .filter_rst(filter_rst), .diag_run(diag_run));

// file: test/host_spi_model.sv
// Host-side serial reader: one result per frame
`timescale 1ns/1ps
module host_spi_model (
   output logic        sclk,
   output logic        cs_n,
   input  wire         dout,
   output logic [23:0] word,
   output logic        word_stb
);
   initial begin
      sclk     = 1'b0;
      cs_n     = 1'b1;
      word     = 24'h000000;
      word_stb = 1'b0;
   end
   // Clock stands low between frames; bits are taken on the rising edge
   task automatic fetch;
      #7 cs_n = 1'b0;
      // Keeps every serial edge clear of the system clock's rising edge
      #143;
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b1;
         word[i] = dout;
         #160 sclk = 1'b0;
         #160;
      end
      cs_n = 1'b1;
      word_stb = 1'b1;
      #10 word_stb = 1'b0;
   endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
`include "adc_mode_defs.vh"
module tb;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rd_q = 1'b0;
   logic [23:0] conv_data = 24'h0;
   logic [31:0] ctl;
   logic [31:0] exp_v;
   logic [31:0] msk_v;
   logic [31:0] q_exp[$];
   logic [23:0] s_exp[$];
   wire  [31:0] rdata;
   wire  [23:0] word;
   wire  [7:0]  diag_run;
   wire         sclk, cs_n, dout, ready_n, regulators_on, clocks_on, osc_on, word_stb;
   wire         ref_on, psw_on, bias_on, modulator_run, filter_rst;
   int          err_total = 0;
   int          compares = 0;
   int          cyc = 0;
   int          n;
   always #20 clock = ~clock;
   // Short counts keep the run brief; checks derive from these values
   adc_mode_ctrl #(.MCLK_DIV(2), .SETTLE_TICKS(4), .ODR_TICKS(2)) u_dut (
      .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .conv_data(conv_data), .sclk(sclk), .cs_n(cs_n), .dout(dout),
      .ready_n(ready_n), .regulators_on(regulators_on), .clocks_on(clocks_on),
      .osc_on(osc_on), .ref_on(ref_on), .psw_on(psw_on), .bias_on(bias_on),
      .modulator_run(modulator_run), .filter_rst(filter_rst), .diag_run(diag_run));
   host_spi_model u_host (.sclk(sclk), .cs_n(cs_n), .dout(dout), .word(word),
      .word_stb(word_stb));
   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic conclude;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask
   // Masked expectation and mask are queued as two notes; the watcher takes both
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      q_exp.push_back({e & m});
      q_exp.push_back(m);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wait_rdy;
      for (n = 0; n < 400 && ready_n !== 1'b0; n++)
         @(posedge clock);
      check("ready_n", 32'h0, {31'h0, ready_n});
   endtask
   always @(posedge clock) begin
      rd_q <= rd;
      cyc++;
      // Notes are taken off one at a time so their order is fixed
      if (rd_q) begin
         exp_v = q_exp.pop_front();
         msk_v = q_exp.pop_front();
         check("rdata", exp_v, rdata & msk_v);
      end
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   always @(posedge word_stb)
      check("serial", {8'h00, s_exp.pop_front()}, {8'h00, word});
   initial begin
      void'($urandom(48));
      repeat (20) @(posedge clock);
      check("reset_pwr", 32'h38, {26'h0, regulators_on, clocks_on, osc_on, ref_on, psw_on,
         bias_on});
      reset <= 1'b0;
      conv_data <= $urandom;
      @(posedge clock);
      rd_reg(`OFS_CTRL, 32'h1000, 32'h793c);
      rd_reg(8'h20, 32'h0, 32'hffffffff);
      wait_rdy();
      check("conv_run", 32'h2, {30'h0, modulator_run, filter_rst});
      rd_reg(`OFS_DATA, {8'h00, conv_data}, 32'hffffffff);
      wr_reg(`OFS_CTRL, 32'h10);
      repeat (3) @(posedge clock);
      check("idle", 32'h7, {29'h0, filter_rst, clocks_on, !modulator_run});
      rd_reg(`OFS_DATA, 32'h0, 32'hffffffff);
      conv_data <= $urandom;
      wr_reg(`OFS_CTRL, 32'h4);
      wait_rdy();
      rd_reg(`OFS_STATUS, 32'h8, 32'h3c);
      repeat (10) @(posedge clock);
      check("hold", 32'h0, {31'h0, ready_n});
      rd_reg(`OFS_DATA, {8'h00, conv_data}, 32'hffffffff);
      check("cleared", 32'h1, {31'h0, ready_n});
      rd_reg(`OFS_DATA, 32'h0, 32'hffffffff);
      for (int i = 0; i < 16; i++) begin
         ctl = 32'h8 | 32'({i[2:0], 12'h000}) | 32'({i[3], 8'h00});
         wr_reg(`OFS_CTRL, ctl);
         repeat (2) @(posedge clock);
         check("standby", {26'h0, 1'b1, i[0], i[3], i[1], i[2], 1'b0}, {26'h0, regulators_on,
            osc_on, ref_on, psw_on, bias_on, modulator_run});
      end
      wr_reg(`OFS_DIAG, 32'hff);
      repeat (3) @(posedge clock);
      check("diag", 32'he0, {24'h0, diag_run});
      rd_reg(`OFS_DIAG, 32'hff, 32'hff);
      rd_reg(`OFS_CTRL, ctl, 32'h793c);
      wr_reg(`OFS_CTRL, 32'hc);
      repeat (3) @(posedge clock);
      check("pdown", 32'h0, {26'h0, regulators_on, clocks_on, osc_on, ref_on, psw_on,
         bias_on});
      rd_reg(`OFS_DIAG, 32'h0, 32'hff);
      rd_reg(`OFS_CTRL, 32'hc, 32'h3c);
      wr_reg(`OFS_DIAG, 32'h0);
      conv_data <= $urandom;
      wr_reg(`OFS_CTRL, 32'h1800);
      repeat (2) begin
         wait_rdy();
         s_exp.push_back(conv_data);
         u_host.fetch();
      end
      wr_reg(`OFS_CTRL, 32'h1000);
      wait_rdy();
      wr_reg(`OFS_COMM, 32'h1);
      s_exp.push_back(conv_data);
      u_host.fetch();
      repeat (4) @(posedge clock);
      conclude();
   end
endmodule
